// file: design/emap_bank_regs.sv
`timescale 1ns/10ps
// One bank page per space, written by the core, read back through a register
module emap_bank_regs #(
	parameter int DEPTH = emap_pkg::BANK_REGS,
	parameter int WIDTH = emap_pkg::BANK_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_idx,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= emap_pkg::BANK_RESET;
			end
		end else if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= emap_pkg::BANK_RESET;
		end else begin
			rd_data <= mem_q[rd_idx];
		end
	end
endmodule

// file: design/emap_pkg.sv
package emap_pkg;
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam int BANK_W = 8;
	localparam int NIB_W = 4;
	localparam int MEMBUS_W = 16;
	localparam int REGBUS_W = 8;
	localparam int IRQBUS_W = 6;
	localparam int BANK_REGS = 2;
	// Bit 15 marks the upper 32 K half that bank bits page
	localparam int PAGE_BIT = 15;
	localparam logic [7:0] BANK_RESET = 8'h00;
	localparam logic [7:0] BUS_IDLE = 8'h00;
	localparam logic SPACE_PROGRAM = 1'b1;
	localparam logic SPACE_DATA = 1'b0;
	typedef enum logic [1:0] {
		EMAP_CMD_NONE,
		EMAP_CMD_SET_DATA,
		EMAP_CMD_SET_PROG
	} emap_cmd_e;
endpackage

// file: design/emap_port.sv
`timescale 1ns/10ps
// Behaviour
// - The muxed port carries address bits 0-7 then data bits 0-7 of each external transfer.
// - Off-chip memory is addressed by the muxed port, the high port (A8-A15) and the low port.
// - Eight bank lines carry address bits 16-23, one per bit in ascending order.
// - A separate eight-line port drives address bits 0-7 unmultiplexed.
// - Without bank switching there are program and data spaces of 65,536 bytes each.
// - With bank switching only the upper 32 K of each space is paged, giving 8 M per space.
// - Every fetch is an external program-space cycle; non-fetch accesses flagged internal stay on-chip.
// - A program/data select is output per cycle and the decoder steers memory by it.
// - The set-data instruction selects data space and set-program selects program space.
// - High and low nibble enable inputs gate the upper and lower four bank bits.
// - The internal memory bus is 16 bits, apart from an 8-bit register and 6-bit irq/DMA bus.
// - The address strobe pulses low once per cycle; address, direction, space valid at its rise.
// - Write data is valid at data strobe fall; read data sampled one cycle before its rise; none on-chip.
// - Read/write is low only for writes to external memory, high otherwise.
module emap_port (
	input wire logic clk,
	input wire logic reset_n,
	// Core side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [emap_pkg::MEMBUS_W-1:0] req_addr,
	input wire logic req_write,
	input wire logic req_fetch,
	input wire logic req_internal,
	input wire logic req_stack,
	input wire logic [emap_pkg::BYTE_W-1:0] req_wdata,
	input wire logic [1:0] space_cmd,
	input wire logic bank_enable,
	input wire logic bank_wr_en,
	input wire logic bank_wr_space,
	input wire logic [emap_pkg::BANK_W-1:0] bank_wr_data,
	input wire logic [emap_pkg::REGBUS_W-1:0] reg_addr,
	input wire logic [emap_pkg::IRQBUS_W-1:0] irq_dma_vec,
	output logic [emap_pkg::REGBUS_W-1:0] reg_addr_q,
	output logic [emap_pkg::IRQBUS_W-1:0] irq_dma_vec_q,
	output logic resp_valid,
	output logic [emap_pkg::BYTE_W-1:0] resp_rdata,
	output logic space_is_program,
	// Pin side
	input wire logic [emap_pkg::BYTE_W-1:0] muxed_addr_data_in,
	output logic [emap_pkg::BYTE_W-1:0] muxed_addr_data_out,
	output logic muxed_addr_data_oe,
	output logic [emap_pkg::BYTE_W-1:0] high_addr,
	output logic [emap_pkg::BYTE_W-1:0] low_addr,
	output logic [emap_pkg::BANK_W-1:0] bank_addr,
	input wire logic bank_high_nibble_enable,
	input wire logic bank_low_nibble_enable,
	output logic prog_data_sel,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic read_write
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_LATCH,
		ST_DATA,
		ST_END
	} emap_state_e;

	emap_state_e state_q;
	logic space_q;
	logic cyc_space_q;
	logic cyc_write_q;
	logic cyc_int_q;
	logic [emap_pkg::MEMBUS_W-1:0] cyc_addr_q;
	logic [emap_pkg::BYTE_W-1:0] cyc_wdata_q;
	logic [emap_pkg::BANK_W-1:0] bank_page;
	logic [1:0] nib_en_sync;
	logic take;
	logic take_space;

	// Bank enables come straight from pins, so they are synchronised first
	emap_sync2 #(.WIDTH(2)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in({bank_high_nibble_enable, bank_low_nibble_enable}),
		.sync_out(nib_en_sync)
	);

	// Page register for the space of the cycle being launched
	emap_bank_regs u_bank (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(bank_wr_en),
		.wr_idx(bank_wr_space),
		.wr_data(bank_wr_data),
		.rd_idx(take_space),
		.rd_data(bank_page)
	);

	function automatic logic [emap_pkg::BANK_W-1:0] bank_bits(
		input logic [emap_pkg::MEMBUS_W-1:0] addr,
		input logic [emap_pkg::BANK_W-1:0] page,
		input logic en,
		input logic [1:0] nib
	);
		logic [emap_pkg::BANK_W-1:0] b;
		b = '0;
		if (en && addr[emap_pkg::PAGE_BIT]) begin
			if (nib[1]) begin
				b[emap_pkg::BANK_W-1:emap_pkg::NIB_W] = page[emap_pkg::BANK_W-1:emap_pkg::NIB_W];
			end
			if (nib[0]) begin
				b[emap_pkg::NIB_W-1:0] = page[emap_pkg::NIB_W-1:0];
			end
		end
		return b;
	endfunction

	// On-chip RAM cycles never turn the external bus around
	function automatic logic ext_write(
		input logic write,
		input logic internal
	);
		return write && !internal;
	endfunction

	assign take = (state_q == ST_IDLE) && req_valid;
	// Fetches always go to program space; stack traffic that is not a fetch always to data space
	always_comb begin
		if (req_fetch) begin
			take_space = emap_pkg::SPACE_PROGRAM;
		end else if (req_stack) begin
			take_space = emap_pkg::SPACE_DATA;
		end else begin
			take_space = space_q;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			space_q <= emap_pkg::SPACE_PROGRAM;
		end else if (space_cmd == 2'(emap_pkg::EMAP_CMD_SET_DATA)) begin
			space_q <= emap_pkg::SPACE_DATA;
		end else if (space_cmd == 2'(emap_pkg::EMAP_CMD_SET_PROG)) begin
			space_q <= emap_pkg::SPACE_PROGRAM;
		end
	end

	// Register and interrupt buses only pass through a stage here
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_addr_q <= '0;
			irq_dma_vec_q <= '0;
		end else begin
			reg_addr_q <= reg_addr;
			irq_dma_vec_q <= irq_dma_vec;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc_addr_q <= '0;
			cyc_wdata_q <= emap_pkg::BUS_IDLE;
			cyc_write_q <= 1'b0;
			cyc_int_q <= 1'b0;
			cyc_space_q <= emap_pkg::SPACE_PROGRAM;
		end else if (take) begin
			cyc_addr_q <= req_addr;
			cyc_wdata_q <= req_wdata;
			cyc_write_q <= req_write;
			cyc_int_q <= req_internal && !req_fetch;
			cyc_space_q <= take_space;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q <= ST_ADDR;
					end
				end
				ST_ADDR: state_q <= ST_LATCH;
				ST_LATCH: state_q <= ST_DATA;
				ST_DATA: state_q <= ST_END;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Address pins; bank page was read in the launch cycle, ready in ST_ADDR
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			high_addr <= emap_pkg::BUS_IDLE;
			low_addr <= emap_pkg::BUS_IDLE;
			bank_addr <= emap_pkg::BANK_RESET;
		end else if (state_q == ST_ADDR) begin
			high_addr <= cyc_addr_q[emap_pkg::MEMBUS_W-1:emap_pkg::BYTE_W];
			low_addr <= cyc_addr_q[emap_pkg::BYTE_W-1:0];
			bank_addr <= bank_bits(cyc_addr_q, bank_page, bank_enable, nib_en_sync);
		end
	end

	// Space select moves only with a new address, so decoders see it steady all cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prog_data_sel <= emap_pkg::SPACE_PROGRAM;
		end else if (state_q == ST_ADDR) begin
			prog_data_sel <= cyc_space_q;
		end
	end

	// One low cycle per memory cycle, on-chip ones included
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			address_strobe_n <= 1'b1;
		end else begin
			address_strobe_n <= !(state_q == ST_ADDR);
		end
	end

	// Direction is set with the address so it is valid at the strobe's rise
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			read_write <= 1'b1;
		end else if (state_q == ST_ADDR) begin
			read_write <= !ext_write(cyc_write_q, cyc_int_q);
		end else if (state_q == ST_END) begin
			read_write <= 1'b1;
		end
	end

	// Low byte pins: address first, then the write byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			muxed_addr_data_out <= emap_pkg::BUS_IDLE;
		end else if (state_q == ST_ADDR) begin
			muxed_addr_data_out <= cyc_addr_q[emap_pkg::BYTE_W-1:0];
		end else if (state_q == ST_LATCH) begin
			muxed_addr_data_out <= cyc_wdata_q;
		end
	end

	// The address is driven on every cycle so the pins never float under the strobe;
	// in the data phase only external writes keep driving
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			muxed_addr_data_oe <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR: begin
					muxed_addr_data_oe <= 1'b1;
				end
				ST_LATCH: begin
					muxed_addr_data_oe <= ext_write(cyc_write_q, cyc_int_q);
				end
				ST_DATA: begin
					muxed_addr_data_oe <= muxed_addr_data_oe;
				end
				default: begin
					muxed_addr_data_oe <= 1'b0;
				end
			endcase
		end
	end

	// Two low cycles; on-chip RAM cycles keep it high throughout
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_strobe_n <= 1'b1;
		end else if (state_q == ST_LATCH || state_q == ST_DATA) begin
			data_strobe_n <= cyc_int_q;
		end else begin
			data_strobe_n <= 1'b1;
		end
	end

	// Read data taken at the end of the first low cycle of the data strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resp_rdata <= emap_pkg::BUS_IDLE;
		end else if (state_q == ST_DATA && !cyc_write_q) begin
			resp_rdata <= muxed_addr_data_in;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resp_valid <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			resp_valid <= (state_q == ST_DATA);
			req_ready <= (state_q == ST_END);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			space_is_program <= emap_pkg::SPACE_PROGRAM;
		end else begin
			space_is_program <= space_q;
		end
	end
endmodule

// file: design/emap_sync2.sv
`timescale 1ns/10ps
module emap_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// file: verification/emap_mem_model.sv
`timescale 1ns/10ps
// Memory byte is picked by the space select and the low address only
module emap_mem_model (
	input wire logic clk,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_write,
	input wire logic prog_data_sel,
	input wire logic [7:0] low_addr,
	input wire logic [7:0] muxed_addr_data_out,
	output logic [7:0] muxed_addr_data_in
);
	logic [7:0] mem [512];
	logic [8:0] a_q;
	logic [7:0] last_q;
	logic drive;
	initial begin
		for (int i = 0; i < 512; i++) mem[i] = ~i[7:0];
		a_q = 9'h000;
		last_q = 8'h00;
	end
	assign drive = !data_strobe_n && read_write;
	// Released bus shows the inverse so a stale byte never passes
	assign muxed_addr_data_in = drive ? mem[a_q] : ~last_q;
	always @(posedge clk) begin
		if (!address_strobe_n) a_q <= {prog_data_sel, low_addr};
		if (!data_strobe_n && !read_write) mem[a_q] <= muxed_addr_data_out;
		last_q <= muxed_addr_data_in;
	end
endmodule

// file: verification/emap_port_properties.sv
`timescale 1ns/10ps
module emap_port_properties (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_write,
	input wire logic muxed_addr_data_oe,
	input wire logic [emap_pkg::BYTE_W-1:0] muxed_addr_data_out,
	input wire logic [emap_pkg::BYTE_W-1:0] low_addr,
	input wire logic [emap_pkg::BYTE_W-1:0] high_addr,
	input wire logic [emap_pkg::BANK_W-1:0] bank_addr,
	input wire logic resp_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	as_single_a: assert property ($fell(address_strobe_n) |=> address_strobe_n [*3])
		else $error("address strobe low for more than one cycle");
	mux_addr_a: assert property (!address_strobe_n |-> muxed_addr_data_oe &&
		muxed_addr_data_out == low_addr) else $error("muxed port not showing address");
	ds_phase_a: assert property ($fell(data_strobe_n) |->
		$past(address_strobe_n) == 1'b0 ##1 !data_strobe_n ##1 data_strobe_n)
		else $error("data strobe out of place");
	read_release_a: assert property (!data_strobe_n && read_write |-> !muxed_addr_data_oe)
		else $error("port driven during read data phase");
	write_drive_a: assert property (!data_strobe_n && !read_write |-> muxed_addr_data_oe)
		else $error("port not driven during write data phase");
	rw_idle_a: assert property (address_strobe_n && data_strobe_n |-> read_write)
		else $error("read_write low outside a transfer");
	resp_time_a: assert property ($fell(address_strobe_n) |-> ##2 resp_valid)
		else $error("response not two cycles after address strobe");
	lower_half_a: assert property (!address_strobe_n && !high_addr[7] |-> bank_addr == 8'h00)
		else $error("bank bits set for lower half");
	addr_hold_a: assert property ($fell(address_strobe_n) |=>
		($stable(high_addr) && $stable(low_addr)) [*2]) else $error("address moved in cycle");
	cover property ($fell(address_strobe_n) ##1 !read_write);
	cover property ($fell(address_strobe_n) ##1 data_strobe_n [*3]);
	cover property (!address_strobe_n && bank_addr != 8'h00);
endmodule

// file: verification/ext_memory_address_space_port_bench.sv
`timescale 1ns/10ps
module ext_memory_address_space_port_bench;
	logic clk, reset_n, req_valid, req_ready, req_write, req_fetch, req_internal, req_stack;
	logic bank_enable, bank_wr_en, bank_wr_space, bank_high_nibble_enable, bank_low_nibble_enable;
	logic resp_valid, space_is_program, muxed_addr_data_oe, prog_data_sel;
	logic address_strobe_n, data_strobe_n, read_write, c_sel, c_rw, c_ds;
	logic [15:0] req_addr;
	logic [7:0] req_wdata, bank_wr_data, reg_addr, reg_addr_q, resp_rdata, muxed_addr_data_in;
	logic [7:0] muxed_addr_data_out, high_addr, low_addr, bank_addr, c_hi, c_lo, c_bank, c_rd;
	logic [1:0] space_cmd;
	logic [5:0] irq_dma_vec, irq_dma_vec_q;
	int n_fail = 0;
	int n_tests = 0;
	emap_port u_emap_port (.clk, .reset_n, .req_valid, .req_ready, .req_addr, .req_write,
		.req_fetch, .req_internal, .req_stack, .req_wdata, .space_cmd, .bank_enable, .bank_wr_en,
		.bank_wr_space, .bank_wr_data, .reg_addr, .irq_dma_vec, .reg_addr_q, .irq_dma_vec_q,
		.resp_valid, .resp_rdata, .space_is_program, .muxed_addr_data_in, .muxed_addr_data_out,
		.muxed_addr_data_oe, .high_addr, .low_addr, .bank_addr, .bank_high_nibble_enable,
		.bank_low_nibble_enable, .prog_data_sel, .address_strobe_n, .data_strobe_n, .read_write);
	emap_mem_model u_emap_mem_model (.clk, .address_strobe_n, .data_strobe_n, .read_write,
		.prog_data_sel, .low_addr, .muxed_addr_data_out, .muxed_addr_data_in);
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input logic [15:0] a, input logic w, f, i, s, input logic [7:0] d);
		@(posedge clk);
		{req_addr, req_write, req_fetch, req_internal, req_stack, req_wdata} <= {a, w, f, i, s, d};
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		c_ds = 1'b1;
		for (int k = 0; k < 8 && req_ready !== 1'b1; k++) begin
			@(posedge clk);
			#1;
			if (data_strobe_n === 1'b0) c_ds = 1'b0;
			if (address_strobe_n === 1'b0)
				{c_hi, c_lo, c_bank, c_sel, c_rw} = {high_addr, low_addr, bank_addr, prog_data_sel, read_write};
			if (resp_valid === 1'b1) c_rd = resp_rdata;
		end
		chk("ready", 1, req_ready);
	endtask
	task automatic set_space(input logic [1:0] c);
		@(posedge clk) space_cmd <= c;
		@(posedge clk) space_cmd <= 2'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic set_nib(input logic h, l);
		@(posedge clk) {bank_high_nibble_enable, bank_low_nibble_enable} <= {h, l};
		repeat (3) @(posedge clk);
	endtask
	task automatic t_mem;
		set_space(emap_pkg::EMAP_CMD_SET_DATA);
		chk("space", 0, space_is_program);
		cyc(16'h1234, 1, 0, 0, 0, 8'h5A);
		chk("high", 8'h12, c_hi);
		chk("low", 8'h34, c_lo);
		chk("sel", 0, c_sel);
		chk("rw", 0, c_rw);
		chk("ds", 0, c_ds);
		cyc(16'h0034, 0, 1, 0, 0, 8'h00);
		chk("fetch", 8'hCB, c_rd);
		chk("sel", 1, c_sel);
		cyc(16'h1234, 0, 0, 0, 0, 8'h00);
		chk("rdata", 8'h5A, c_rd);
		chk("rw", 1, c_rw);
		set_space(emap_pkg::EMAP_CMD_SET_PROG);
		cyc(16'h0040, 0, 0, 0, 1, 8'h00);
		chk("stack", 0, c_sel);
		chk("rdata", 8'hBF, c_rd);
		cyc(16'h0077, 0, 0, 1, 0, 8'h00);
		chk("ds", 1, c_ds);
		chk("sel", 1, c_sel);
	endtask
	task automatic t_bank;
		@(posedge clk);
		{bank_wr_en, bank_wr_space, bank_wr_data, bank_enable} <= {1'b1, 1'b1, 8'hA5, 1'b1};
		@(posedge clk) bank_wr_en <= 1'b0;
		set_nib(1, 0);
		cyc(16'h8012, 0, 1, 0, 0, 8'h00);
		chk("bank", 8'hA0, c_bank);
		chk("high", 8'h80, c_hi);
		set_nib(0, 1);
		cyc(16'h8012, 0, 1, 0, 0, 8'h00);
		chk("bank", 8'h05, c_bank);
		cyc(16'h0012, 0, 1, 0, 0, 8'h00);
		chk("bank", 8'h00, c_bank);
		cyc(16'h8012, 0, 0, 0, 1, 8'h00);
		chk("bank", 8'h00, c_bank);
		@(posedge clk) bank_enable <= 1'b0;
		cyc(16'h8012, 0, 1, 0, 0, 8'h00);
		chk("bank", 8'h00, c_bank);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#50000;
		n_fail++;
		final_report();
	end
	initial begin
		{reset_n, req_valid, req_write, req_fetch, req_internal, req_stack} = 6'h00;
		{bank_enable, bank_wr_en, bank_wr_space, bank_high_nibble_enable} = 4'h0;
		{bank_low_nibble_enable, req_addr, req_wdata, bank_wr_data, space_cmd} = 35'h0;
		{reg_addr, irq_dma_vec} = 14'h0000;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		chk("as", 1, address_strobe_n);
		chk("rw", 1, read_write);
		chk("space", 1, space_is_program);
		t_mem();
		t_bank();
		@(posedge clk) {reg_addr, irq_dma_vec} <= {8'h5C, 6'h2A};
		repeat (2) @(posedge clk);
		#1;
		chk("reg", 8'h5C, reg_addr_q);
		chk("irq", 6'h2A, irq_dma_vec_q);
		final_report();
	end
endmodule
bind emap_port emap_port_properties u_emap_port_properties (.clk, .reset_n, .address_strobe_n,
	.data_strobe_n, .read_write, .muxed_addr_data_oe, .muxed_addr_data_out, .low_addr, .high_addr,
	.bank_addr, .resp_valid);
